// ---- verilog/bto_regs.vh ----
// Constants for the bit invert and overflow branch execution block.
`ifndef BTO_REGS_VH
`define BTO_REGS_VH
`define BTO_OPC_INVERT     4'h7
`define BTO_OPC_BRANCH     8'he4
`define BTO_ACCESS_SPLIT   8'h80
`define BTO_ACCESS_HI_BANK 4'hf
`define BTO_PC_RESET       21'h000000
`define BTO_QUARTERS       2'h3
`endif

// ---- verilog/bto_phase.v ----
// Quarter phase generator for one instruction cycle.
`include "bto_regs.vh"

module bto_phase (
  // Clock and reset.
  input  wire       mclk,
  input  wire       rst_n,
  // Run enable and phase outputs.
  input  wire       run,
  output wire [1:0] phase,
  output wire       cycle_end
);

  reg [1:0] phase_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else if (run) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign phase     = phase_q;
  assign cycle_end = run && (phase_q == `BTO_QUARTERS);

endmodule // bto_phase

// ---- verilog/bto_core.v ----
// Execution of the bit invert and overflow branch instructions.
`include "bto_regs.vh"

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Bit invert flips only the indexed bit of the addressed data byte.
// - Access bit zero selects the access bank, ignoring the bank select.
// - Access bit one joins bank select register and file address.
// - Invert: decode, read, modify in the first three quarters, write strobe in the next first quarter.
module bto_core #(
  parameter PC_W = 21
) (
  // Clock and reset.
  input  wire            mclk,
  input  wire            rst_n,
  // Instruction fetch.
  input  wire [15:0]     instr,
  input  wire            instr_valid,
  output wire            instr_ready,
  // Core state.
  input  wire [3:0]      bank_select_register,
  input  wire            overflow_flag,
  // Data memory.
  output wire [11:0]     mem_addr,
  output wire            mem_rd,
  input  wire [7:0]      mem_rdata,
  output wire            mem_wr,
  output wire [7:0]      mem_wdata,
  // Program counter and phases.
  output wire [PC_W-1:0] pc,
  output wire            first_quarter_phase,
  output wire            fourth_quarter_phase,
  output wire            illegal_op
);

  ////////////////////////////////////////////////////////////////////////////
  // Machine states and storage.

  localparam ST_RUN  = 1'b0;
  localparam ST_IDLE = 1'b1;

  reg            state_q;
  reg            state_d;
  reg [15:0]     ir_q;
  reg [15:0]     ir_d;
  reg [7:0]      data_q;
  reg [7:0]      data_d;
  reg [11:0]     addr_q;
  reg [11:0]     addr_d;
  reg            rd_q;
  reg            rd_d;
  reg            wr_q;
  reg            wr_d;
  reg [7:0]      wdata_q;
  reg [7:0]      wdata_d;
  reg [PC_W-1:0] pc_q;
  reg [PC_W-1:0] pc_d;
  reg            illegal_q;
  reg            illegal_d;
  wire [1:0]     phase;
  wire           cycle_end;
  wire           ir_inv;
  wire           ir_bov;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter phases.

  // The phase counter free-runs; the idle branch cycle is kept by state_q.
  bto_phase u_phase (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .run       (1'b1),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  assign first_quarter_phase  = (phase == 2'h0);
  assign fourth_quarter_phase = cycle_end;
  // An instruction is taken only at the first quarter of a working cycle.
  assign instr_ready = first_quarter_phase && (state_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function is_invert;
    input [15:0] word;
    begin
      is_invert = (word[15:12] == `BTO_OPC_INVERT);
    end
  endfunction

  function is_branch;
    input [15:0] word;
    begin
      is_branch = (word[15:8] == `BTO_OPC_BRANCH);
    end
  endfunction

  function [11:0] eff_addr;
    input [7:0] f;
    input       a;
    input [3:0] bank;
    begin
      if (!a) begin
        // Low half of the access bank is bank zero, high half the top bank.
        eff_addr = (f < `BTO_ACCESS_SPLIT) ? {4'h0, f}
                                           : {`BTO_ACCESS_HI_BANK, f};
      end else begin
        eff_addr = {bank, f};
      end
    end
  endfunction

  function [7:0] flip_bit;
    input [7:0] data;
    input [2:0] idx;
    begin
      flip_bit = data ^ (8'h01 << idx);
    end
  endfunction

  // The offset counts words, so it is doubled and sign extended to the PC.
  function [PC_W-1:0] word_offset;
    input [7:0] n;
    begin
      word_offset = {{(PC_W-9){n[7]}}, n, 1'b0};
    end
  endfunction

  assign ir_inv = is_invert(ir_q);
  assign ir_bov = is_branch(ir_q);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always @* begin
    state_d   = state_q;
    ir_d      = ir_q;
    data_d    = data_q;
    addr_d    = addr_q;
    rd_d      = 1'b0;
    wr_d      = 1'b0;
    wdata_d   = wdata_q;
    pc_d      = pc_q;
    illegal_d = illegal_q;
    case (phase)
      2'h0: begin
        if (instr_ready && instr_valid) begin
          ir_d      = instr;
          pc_d      = pc_q + {{(PC_W-2){1'b0}}, 2'h2};
          illegal_d = !is_invert(instr) && !is_branch(instr);
          addr_d    = eff_addr(instr[7:0], instr[8],
                               bank_select_register);
          rd_d      = is_invert(instr);
        end else begin
          // An empty slot or the idle cycle must not replay the old word.
          ir_d = 16'h0000;
        end
      end

      2'h1: begin
        data_d = mem_rdata;
      end

      2'h2: begin
        if (ir_inv) begin
          wdata_d = flip_bit(data_q, ir_q[11:9]);
        end
      end

      2'h3: begin
        if (state_q == ST_IDLE) begin
          state_d = ST_RUN;
        end else if (ir_inv) begin
          wr_d = 1'b1;
        end else if (ir_bov && overflow_flag) begin
          pc_d    = pc_q + word_offset(ir_q[7:0]);
          state_d = ST_IDLE;
        end
      end

      default: begin
        state_d = state_q;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // The write strobe lands in the next first quarter, so the byte is stable.
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q   <= ST_RUN;
      ir_q      <= 16'h0000;
      data_q    <= 8'h00;
      addr_q    <= 12'h000;
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      wdata_q   <= 8'h00;
      pc_q      <= `BTO_PC_RESET;
      illegal_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      ir_q      <= ir_d;
      data_q    <= data_d;
      addr_q    <= addr_d;
      rd_q      <= rd_d;
      wr_q      <= wr_d;
      wdata_q   <= wdata_d;
      pc_q      <= pc_d;
      illegal_q <= illegal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign mem_addr   = addr_q;
  assign mem_rd     = rd_q;
  assign mem_wr     = wr_q;
  assign mem_wdata  = wdata_q;
  assign pc         = pc_q;
  assign illegal_op = illegal_q;

endmodule // bto_core

// ---- tb/bto_core_sva.sv ----
// Checker for the bit invert and overflow branch block.
`include "bto_regs.vh"
module bto_core_sva #(
  parameter PC_W = 21
) (
  // Clock and reset.
  input wire            mclk,
  input wire            rst_n,
  // Instruction fetch.
  input wire [15:0]     instr,
  input wire            instr_valid,
  input wire            instr_ready,
  // Core state.
  input wire [3:0]      bank_select_register,
  input wire            overflow_flag,
  // Data memory and program counter.
  input wire            mem_rd,
  input wire            mem_wr,
  input wire [7:0]      mem_rdata,
  input wire [7:0]      mem_wdata,
  input wire [11:0]     mem_addr,
  input wire [PC_W-1:0] pc
);
  timeunit 1ns;
  timeprecision 1ns;
  wire ti = instr_valid && instr_ready && instr[15:12] == `BTO_OPC_INVERT;
  wire tb = instr_valid && instr_ready && instr[15:8] == `BTO_OPC_BRANCH;
  wire [PC_W-1:0] offs = {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_read_strobe: assert property (ti |=> mem_rd)
    else $error("read strobe missing");
  chk_write_slot: assert property (ti |-> ##4 mem_wr)
    else $error("write strobe missing");
  chk_bit_flip: assert property (ti |-> ##4 mem_wdata ==
    ($past(mem_rdata, 3) ^ (8'h01 << $past(instr[11:9], 4))))
    else $error("wrong written byte");
  chk_access_bank: assert property (ti && !instr[8] |=> mem_addr ==
    {($past(instr[7]) ? `BTO_ACCESS_HI_BANK : 4'h0), $past(instr[7:0])})
    else $error("wrong access bank address");
  chk_bank_select: assert property (ti && instr[8] |=> mem_addr ==
    {$past(bank_select_register), $past(instr[7:0])})
    else $error("wrong banked address");
  // The sum is cut to the counter width so a backward branch wraps as pc does.
  chk_branch_pc: assert property (tb |-> ##4 pc == PC_W'(
    $past(pc, 4) + 2 + ($past(overflow_flag) ? $past(offs, 4) : 0)))
    else $error("wrong branch target");
  chk_branch_idle: assert property (tb ##3 overflow_flag
    |=> !instr_ready [*4]) else $error("no idle cycle");
  chk_branch_quiet: assert property (tb |=> !mem_rd ##3 !mem_wr)
    else $error("branch touched data memory");
endmodule // bto_core_sva
bind bto_core bto_core_sva #(.PC_W(PC_W)) u_sva (.mclk, .rst_n, .instr,
  .instr_valid, .instr_ready, .bank_select_register, .overflow_flag,
  .mem_rd, .mem_wr, .mem_rdata, .mem_wdata, .mem_addr, .pc);

// ---- tb/testbench.sv ----
// Testbench for the bit invert and overflow branch block.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, instr_valid, overflow_flag;
  logic [15:0] instr;
  logic [3:0]  bank_select_register;
  logic [7:0]  mem_rdata;
  wire         instr_ready, mem_wr, first_quarter_phase;
  wire         fourth_quarter_phase, illegal_op;
  wire  [11:0] mem_addr;
  wire  [7:0]  mem_wdata;
  wire  [20:0] pc;
  logic [20:0] p;
  int          n_fail = 0, n_checks = 0;
  // Rows: word, bank, read byte, address, written byte.
  logic [47:0] rows [4] = '{48'h7882_3_75_f82_65, 48'h7010_5_00_010_01,
                            48'h7f10_a_ff_a10_7f, 48'h77c4_0_08_0c4_00};
  bto_core dut (.mclk, .rst_n, .instr, .instr_valid, .instr_ready,
    .bank_select_register, .overflow_flag, .mem_addr, .mem_rd(),
    .mem_rdata, .mem_wr, .mem_wdata, .pc, .first_quarter_phase,
    .fourth_quarter_phase, .illegal_op);
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task cmp_pc(string n, logic [20:0] e, logic [20:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp_addr(string n, logic [11:0] e, logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp_byte(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp_bit(string n, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Waiting on ready rather than the phase skips the idle branch cycle.
  task issue(logic [15:0] w);
    @(negedge mclk);
    while (!instr_ready) @(negedge mclk);
    p = pc;
    instr = w;
    instr_valid = 1;
    @(negedge mclk);
    instr_valid = 0;
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    #3000;
    n_fail++;
    summarize;
  end
  initial begin
    {rst_n, instr_valid, overflow_flag, instr} = 0;
    {bank_select_register, mem_rdata} = 0;
    repeat (20) @(negedge mclk);
    cmp_pc("pc", 21'h0, pc);
    cmp_bit("q1", 1'b1, first_quarter_phase);
    $display("reset test done");
    rst_n = 1;
    foreach (rows[i]) begin
      bank_select_register = rows[i][31:28];
      mem_rdata = rows[i][27:20];
      issue(rows[i][47:32]);
      cmp_addr("addr", rows[i][19:8], mem_addr);
      cmp_byte("wdata", rows[i][7:0], mem_wdata);
      cmp_bit("wr", 1'b1, mem_wr);
      cmp_bit("illegal", 1'b0, illegal_op);
      cmp_bit("q1", 1'b1, first_quarter_phase);
      $display("invert row %0d done", i);
    end
    overflow_flag = 1;
    issue(16'he4fd);
    cmp_pc("pc", p - 21'h4, pc);
    cmp_bit("ready", 1'b0, instr_ready);
    cmp_bit("wr", 1'b0, mem_wr);
    overflow_flag = 0;
    issue(16'he405);
    cmp_pc("pc", p + 21'h2, pc);
    cmp_bit("ready", 1'b1, instr_ready);
    $display("branch tests done");
    issue(16'h0123);
    cmp_bit("illegal", 1'b1, illegal_op);
    cmp_bit("wr", 1'b0, mem_wr);
    cmp_pc("pc", p + 21'h2, pc);
    repeat (3) @(negedge mclk);
    cmp_bit("q4", 1'b1, fourth_quarter_phase);
    $display("other word test done");
    rst_n = 0;
    repeat (2) @(negedge mclk);
    cmp_pc("pc", 21'h0, pc);
    cmp_bit("q1", 1'b1, first_quarter_phase);
    rst_n = 1;
    $display("second reset test done");
    summarize;
  end
endmodule // testbench
